// ### ctp_cfg.svh
// Purpose: constants for the cascadable timer pair
// Assumes: 16-bit register port, 10 MHz clock
// Notes:   offsets and status layout are local choices
`ifndef CTP_CFG_SVH
`define CTP_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CTP_A_LOW_CTL   4'h0
`define CTP_A_HIGH_CTL  4'h1
`define CTP_A_LOW_CNT   4'h2
`define CTP_A_HIGH_CNT  4'h3
`define CTP_A_LOW_PER   4'h4
`define CTP_A_HIGH_PER  4'h5
`define CTP_A_STATUS    4'h6
`define CTP_A_MASK      4'h7

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTP_B_RUN       15
`define CTP_B_IDLE      13
`define CTP_B_GATE      6
`define CTP_B_PS_HI     5
`define CTP_B_PS_LO     4
`define CTP_B_JOIN      3
`define CTP_B_CSRC      1
`define CTP_LOW_WMASK   16'hA07A
`define CTP_HIGH_WMASK  16'hA072

// ----------------------------------------
// reset values and prescale terminal counts
// ----------------------------------------
`define CTP_RST_CTL     16'h0000
`define CTP_RST_PER     16'hFFFF
`define CTP_RST_CNT     16'h0000
`define CTP_RST_FLAGS   3'h0
`define CTP_PS_1        8'h00
`define CTP_PS_8        8'h07
`define CTP_PS_64       8'h3F
`define CTP_PS_256      8'hFF

`endif

// ### ctp_pin_model.sv
// Purpose: external clock pin source for the timer pair
// Assumes: pin changes just after a system clock edge
// Notes:   stands low while disabled
`timescale 1ns/1ps
module ctp_pin_model (
  input  wire logic i_sys_clk,
  input  wire logic i_en,
  output logic      o_pin
);
  logic [1:0] ph = 2'h0;
  initial o_pin = 1'b0;
  // four-clock period so each rising edge is seen
  always @(posedge i_sys_clk) begin
    ph    <= i_en ? ph + 2'h1 : 2'h0;
    o_pin <= i_en & ph[1];
  end
endmodule

// ### ctp_pkg.sv
// Purpose: types for the cascadable timer pair
// Assumes: included config header defines constants
// Notes:   one struct per timer half
package ctp_pkg;

  typedef enum logic [1:0] {
    CTP_IDLE_ST = 2'b01,
    CTP_RUN_ST  = 2'b10
  } ctp_mode_e;

  typedef struct packed {
    logic [15:0] ctl;
    logic [15:0] cnt;
    logic [15:0] per;
    logic [7:0]  ps;
    logic        ext_q;
    logic        gate_q;
  } ctp_half_s;

  typedef struct packed {
    ctp_half_s   lo;
    ctp_half_s   hi;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [15:0] rdata;
    logic        irq;
    ctp_mode_e   mode;
  } ctp_state_s;

endpackage

// ### ctp_timer_pair.sv
// Purpose: two 16-bit timers joinable into one 32-bit timer
// Assumes: pins synchronous to i_sys_clk; one-cycle strobes
// Assumes: bus strobes are never both high
// Notes:   status bits clear on read; set wins over clear
// Notes:   gated mode counts while the gate is high
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "ctp_cfg.svh"

module ctp_timer_pair (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_idle,
  input  wire logic        i_low_timer_ext_clock_pin,
  input  wire logic        i_high_timer_ext_clock_pin,
  input  wire logic        i_low_gate,
  input  wire logic        i_high_gate,
  output logic      [15:0] o_rdata,
  output logic             o_irq,
  output logic      [1:0]  o_mode
);
  import ctp_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  ctp_state_s st;
  ctp_state_s next_st;

  // ----------------------------------------
  // prescale terminal count
  // ----------------------------------------
  // terminal count is the divide ratio minus one
  // prescale decode
  function automatic logic [7:0] ps_top(input logic [1:0] sel);
    logic [7:0] t;
    t = `CTP_PS_1;
    case (sel)
      2'b01:   t = `CTP_PS_8;
      2'b10:   t = `CTP_PS_64;
      2'b11:   t = `CTP_PS_256;
      default: t = `CTP_PS_1;
    endcase
    return t;
  endfunction

  // ----------------------------------------
  // raw input tick
  // ----------------------------------------
  // one half, before the prescaler
  function automatic logic raw_tick(input logic [15:0] ctl, input logic ext_now,
                                    input logic ext_q, input logic gate_now,
                                    input logic gate_q);
    logic r;
    r = 1'b0;
    if (ctl[`CTP_B_CSRC]) begin
      r = ext_now & ~ext_q;
    end else if (ctl[`CTP_B_GATE]) begin
      // gated accumulation
      // counting on the gate falling edge is dropped: the gate simply enables ticks
      r = gate_now;
    end else begin
      r = 1'b1;
    end
    return r;
  endfunction

  // ----------------------------------------
  // combinational helpers
  // ----------------------------------------
  // enables and raw ticks
  logic        join_on;
  logic        lo_en;
  logic        hi_en;
  logic        lo_raw;
  logic        hi_raw;
  logic        lo_tick;
  logic        hi_tick;
  logic [7:0]  lo_top;
  logic [7:0]  hi_top;
  // compares and events
  logic [31:0] cnt32;
  logic [31:0] per32;
  logic        lo_match;
  logic        hi_match;
  logic        j_match;
  logic        rd_clr;
  logic [2:0]  ev;
  // gate_q is kept as pin history only; gated counting is level based

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    // counting first, bus writes last, so a write overrides a tick
    next_st = st;

    join_on = st.lo.ctl[`CTP_B_JOIN];
    lo_en = st.lo.ctl[`CTP_B_RUN];
    if (i_idle && st.lo.ctl[`CTP_B_IDLE]) begin
      lo_en = 1'b0;
    end
    // joined pair also halts on high halt bit
    if (join_on && i_idle && st.hi.ctl[`CTP_B_IDLE]) begin
      lo_en = 1'b0;
    end
    hi_en = st.hi.ctl[`CTP_B_RUN];
    if (i_idle && st.hi.ctl[`CTP_B_IDLE]) begin
      hi_en = 1'b0;
    end
    if (join_on) begin
      hi_en = 1'b0;
    end

    // ----------------------------------------
    // input ticks and pin history
    // ----------------------------------------
    // low clock and gate drive the pair
    lo_raw = raw_tick(st.lo.ctl, i_low_timer_ext_clock_pin, st.lo.ext_q,
                      i_low_gate, st.lo.gate_q);
    hi_raw = raw_tick(st.hi.ctl, i_high_timer_ext_clock_pin, st.hi.ext_q,
                      i_high_gate, st.hi.gate_q);
    // history taken every cycle, so an edge is never counted twice
    next_st.lo.ext_q  = i_low_timer_ext_clock_pin;
    next_st.lo.gate_q = i_low_gate;
    next_st.hi.ext_q  = i_high_timer_ext_clock_pin;
    next_st.hi.gate_q = i_high_gate;

    // ----------------------------------------
    // prescalers
    // ----------------------------------------
    lo_tick = 1'b0;
    hi_tick = 1'b0;
    lo_top  = ps_top(st.lo.ctl[`CTP_B_PS_HI:`CTP_B_PS_LO]);
    hi_top  = ps_top(st.hi.ctl[`CTP_B_PS_HI:`CTP_B_PS_LO]);
    // >= so a smaller ratio chosen mid-count wraps at once
    // prescaler low
    if (lo_en && lo_raw) begin
      if (st.lo.ps >= lo_top) begin
        next_st.lo.ps = `CTP_PS_1;
        lo_tick = 1'b1;
      end else begin
        next_st.lo.ps = st.lo.ps + 8'h01;
      end
    end

    if (hi_en && hi_raw) begin
      if (st.hi.ps >= hi_top) begin
        next_st.hi.ps = `CTP_PS_1;
        hi_tick = 1'b1;
      end else begin
        next_st.hi.ps = st.hi.ps + 8'h01;
      end
    end

    // ----------------------------------------
    // counters
    // ----------------------------------------
    // low lsw, high msw
    cnt32    = {st.hi.cnt, st.lo.cnt};
    per32    = {st.hi.per, st.lo.per};

    lo_match = st.lo.cnt == st.lo.per;
    hi_match = st.hi.cnt == st.hi.per;
    j_match  = cnt32 == per32;
    ev = 3'h0;

    if (join_on) begin
      if (lo_tick) begin
        if (j_match) begin
          next_st.lo.cnt = 16'h0000;
          next_st.hi.cnt = 16'h0000;
          ev[2] = 1'b1;
        end else begin
          // one 32-bit add carries into the msw in the same cycle
          {next_st.hi.cnt, next_st.lo.cnt} = cnt32 + 32'h0000_0001;
        end
      end
    end else begin
      if (lo_tick) begin
        if (lo_match) begin
          next_st.lo.cnt = 16'h0000;
          ev[0] = 1'b1;
        end else begin
          next_st.lo.cnt = st.lo.cnt + 16'h0001;
        end
      end

      if (hi_tick) begin
        if (hi_match) begin
          next_st.hi.cnt = 16'h0000;
          ev[1] = 1'b1;
        end else begin
          next_st.hi.cnt = st.hi.cnt + 16'h0001;
        end
      end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // a write to a counter overrides counting
    if (i_wr) begin
      if (i_addr == `CTP_A_LOW_CTL) begin
        next_st.lo.ctl = i_wdata & `CTP_LOW_WMASK;
      end else if (i_addr == `CTP_A_HIGH_CTL) begin
        next_st.hi.ctl = i_wdata & `CTP_HIGH_WMASK;
      end else if (i_addr == `CTP_A_LOW_CNT) begin
        // count writes win over a tick this cycle
        next_st.lo.cnt = i_wdata;
      end else if (i_addr == `CTP_A_HIGH_CNT) begin
        next_st.hi.cnt = i_wdata;
      end else if (i_addr == `CTP_A_LOW_PER) begin
        next_st.lo.per = i_wdata;
      end else if (i_addr == `CTP_A_HIGH_PER) begin
        next_st.hi.per = i_wdata;
      end else if (i_addr == `CTP_A_MASK) begin
        // interrupt mask
        next_st.mask = i_wdata[2:0];
      end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    // unmapped addresses return zero
    // rdata is zero outside a read so no stale value lingers
    next_st.rdata = 16'h0000;
    if (i_rd) begin
      if (i_addr == `CTP_A_LOW_CTL) begin
        next_st.rdata = st.lo.ctl;
      end else if (i_addr == `CTP_A_HIGH_CTL) begin
        next_st.rdata = st.hi.ctl;
      end else if (i_addr == `CTP_A_LOW_CNT) begin
        next_st.rdata = st.lo.cnt;
      end else if (i_addr == `CTP_A_HIGH_CNT) begin
        next_st.rdata = st.hi.cnt;
      end else if (i_addr == `CTP_A_LOW_PER) begin
        next_st.rdata = st.lo.per;
      end else if (i_addr == `CTP_A_HIGH_PER) begin
        next_st.rdata = st.hi.per;
      end else if (i_addr == `CTP_A_STATUS) begin
        // a status read also clears it below
        next_st.rdata = {13'h0000, st.status};
      end else if (i_addr == `CTP_A_MASK) begin
        next_st.rdata = {13'h0000, st.mask};
      end
    end

    // ----------------------------------------
    // status and outputs
    // ----------------------------------------
    // sticky status; a new event wins over the read clear
    rd_clr = i_rd && (i_addr == `CTP_A_STATUS);
    if (rd_clr) begin
      next_st.status = ev;
    end else begin
      next_st.status = st.status | ev;
    end
    // irq from next state so it changes in the same cycle as the status
    next_st.irq  = |(next_st.status & next_st.mask);
    // mode only reports; nothing inside depends on it
    next_st.mode = (lo_en | hi_en) ? CTP_RUN_ST : CTP_IDLE_ST;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // low half
      st.lo.ctl    <= `CTP_RST_CTL;
      st.lo.cnt    <= `CTP_RST_CNT;
      st.lo.per    <= `CTP_RST_PER;
      st.lo.ps     <= `CTP_PS_1;
      st.lo.ext_q  <= 1'b0;
      st.lo.gate_q <= 1'b0;

      // high half
      st.hi.ctl    <= `CTP_RST_CTL;
      st.hi.cnt    <= `CTP_RST_CNT;
      st.hi.per    <= `CTP_RST_PER;
      st.hi.ps     <= `CTP_PS_1;
      st.hi.ext_q  <= 1'b0;
      st.hi.gate_q <= 1'b0;

      // shared status and bus; prescalers clear only here or on wrap
      st.status    <= `CTP_RST_FLAGS;
      st.mask      <= `CTP_RST_FLAGS;
      st.rdata     <= `CTP_RST_CNT;
      st.irq       <= 1'b0;
      st.mode      <= CTP_IDLE_ST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a register bit, no logic after the flops
  assign o_rdata = st.rdata;
  assign o_irq   = st.irq;
  assign o_mode  = st.mode;

endmodule

// ### ctp_timer_pair_sva.sv
// Purpose: port checks for ctp_timer_pair
// Assumes: one clock, async active-low reset
// Notes:   control and mask mirrored from bus writes
`timescale 1ns/1ps
module ctp_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_idle,
  input wire logic [15:0] o_rdata,
  input wire logic        o_irq,
  input wire logic [1:0]  o_mode
);
  logic [15:0] lo, hi;
  logic [2:0]  msk;
  wire         tch = (i_rd && i_addr == 4'h6) || (i_wr && i_addr == 4'h7);
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lo  <= 16'h0000;
      hi  <= 16'h0000;
      msk <= 3'h0;
    end else if (i_wr) begin
      lo  <= (i_addr == 4'h0) ? i_wdata : lo;
      hi  <= (i_addr == 4'h1) ? i_wdata : hi;
      msk <= (i_addr == 4'h7) ? i_wdata[2:0] : msk;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_rd(a); i_rd && i_addr == a; endsequence
  sequence s_go(a); i_wr && i_addr == a && i_wdata[15]; endsequence
  property p_lo_pad; s_rd(4'h0) |=> (o_rdata & 16'h5F85) == 16'h0000; endproperty
  a_lo_pad: assert property (p_lo_pad) else $error("low pad bits set");
  property p_hi_pad; s_rd(4'h1) |=> (o_rdata & 16'h5F8D) == 16'h0000; endproperty
  a_hi_pad: assert property (p_hi_pad) else $error("high pad bits set");
  property p_unmap; i_rd && i_addr[3] |=> o_rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_lo_run;
    s_go(4'h0) ##0 (i_wdata[3] && !(i_idle && (i_wdata[13] || hi[13])))
    |=> ##[0:1] o_mode == 2'b10;
  endproperty
  a_lo_run: assert property (p_lo_run) else $error("pair did not start");
  property p_hi_run;
    s_go(4'h1) ##0 (!lo[3] && !(i_idle && i_wdata[13])) |=> ##[0:1] o_mode == 2'b10;
  endproperty
  a_hi_run: assert property (p_hi_run) else $error("high did not start");
  property p_off; (!lo[15] && !hi[15]) [*3] |-> o_mode == 2'b01; endproperty
  a_off: assert property (p_off) else $error("mode run while stopped");
  property p_mask; (msk == 3'h0) [*2] |-> !o_irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_hold; o_irq && !tch && !$past(tch) |=> o_irq; endproperty
  a_hold: assert property (p_hold) else $error("irq not sticky");
endmodule
bind ctp_timer_pair ctp_sva u_sva (.*);

// ### tb_ctp_timer_pair.sv
// Purpose: self-checking bench for ctp_timer_pair
// Assumes: 10 MHz clock, one-cycle bus strobes
// Notes:   rates judged by count deltas, so prescaler phase is moot
`timescale 1ns/1ps
module tb_ctp_timer_pair;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_idle = 1'b0;
  logic        i_low_gate = 1'b0;
  logic        pin_en = 1'b0;
  logic        pin, o_irq;
  logic [1:0]  o_mode;
  logic [15:0] o_rdata, v, d;
  logic [18:0] tab [8] = '{19'h08002, 19'h08042, 19'h08040, 19'h28040,
                           19'h1A000, 19'h18000, 19'h48002, 19'h7A040};
  int          errors = 0;
  int          n_compared = 0;
  int          k;
  wire         i_low_timer_ext_clock_pin = pin;
  wire         i_high_timer_ext_clock_pin = pin;
  wire         i_high_gate = i_low_gate;
  always #50 i_sys_clk = ~i_sys_clk;
  ctp_timer_pair DUT (.*);
  ctp_pin_model u_pin (.i_sys_clk(i_sys_clk), .i_en(pin_en), .o_pin(pin));
  function automatic int rate(int p);
    return (p == 0) ? 1 : (p == 1) ? 8 : (p == 2) ? 64 : 256;
  endfunction
  function automatic logic [15:0] exp_d(logic [15:0] c, logic g, logic id);
    if (id && c[13])
      return 16'h0000;
    if (c[1])
      return 16'h0008;
    return (c[6] && !g) ? 16'h0000 : 16'h0020;
  endfunction
  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] x);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= x;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    q = o_rdata;
  endtask
  task automatic meas(input logic [3:0] t, input logic [15:0] c, input int w);
    wr(t, c);
    rd(t + 4'h2, v);
    repeat (w - 2) @(posedge i_sys_clk);
    rd(t + 4'h2, d);
    d = d - v;
    wr(t, 16'h0000);
  endtask
  task automatic wait_irq;
    for (k = 0; k < 40 && o_irq !== 1'b1; k++)
      @(negedge i_sys_clk);
    chk("irq", 16'h0001, {15'h0, o_irq});
    if (o_irq !== 1'b1)
      stop_test();
  endtask
  initial begin
    k = $urandom(11);
    repeat (12) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    pin_en  <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), v);
      chk("reset", (a == 4 || a == 5) ? 16'hFFFF : 16'h0000, v);
    end
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      wr(4'(i % 2), d);
      rd(4'(i % 2), v);
      chk("control", d & ((i % 2) ? 16'hA072 : 16'hA07A), v);
    end
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    $display("end registers");
    for (int p = 0; p < 4; p++) begin
      meas(4'h0, 16'h8000 | 16'(p << 4), 8 * rate(p));
      chk("prescale", 16'h0008, d);
    end
    foreach (tab[i]) begin
      i_low_gate <= tab[i][17];
      i_idle     <= tab[i][16];
      meas({3'h0, tab[i][18]}, tab[i][15:0], 32);
      chk("source", exp_d(tab[i][15:0], tab[i][17], tab[i][16]), d);
    end
    $display("end modes");
    wr(4'h2, 16'hFFFD);
    wr(4'h3, 16'h0002);
    // high halt bit clear to run in idle
    wr(4'h1, 16'h8032);
    i_idle <= 1'b1;
    wr(4'h0, 16'h8008);
    repeat (4) @(posedge i_sys_clk);
    wr(4'h0, 16'h0008);
    rd(4'h3, v);
    chk("msw", 16'h0003, v);
    rd(4'h2, v);
    chk("lsw", 16'h0003, v);
    $display("end joined");
    wr(4'h7, 16'h0004);
    wr(4'h4, 16'h0002);
    wr(4'h5, 16'h0001);
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h0001);
    wr(4'h0, 16'h8008);
    wait_irq();
    wr(4'h0, 16'h0008);
    rd(4'h6, v);
    chk("status", 16'h0004, v);
    rd(4'h3, v);
    chk("wrap", 16'h0000, v);
    chk("irq clear", 16'h0000, {15'h0, o_irq});
    $display("end pair irq");
    wr(4'h7, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h4, 16'h0003);
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h8000);
    repeat (12) @(posedge i_sys_clk);
    chk("masked", 16'h0000, {15'h0, o_irq});
    wr(4'h7, 16'h0001);
    wait_irq();
    wr(4'h0, 16'h0000);
    rd(4'h6, v);
    chk("status", 16'h0001, v);
    $display("end split irq");
    stop_test();
  end
endmodule
